// [rtl/hpp_pkg.sv]
// package for the hub port power and overcurrent block
// assumes a single system clock and a synchronous active-high reset
package hpp_pkg;

    localparam int HPP_EXT_PORTS = 4;

    // hub status byte layout
    localparam int HPP_HUB_STATUS_REG_OC_EN_BIT = 7;
    localparam int HPP_HUB_STATUS_REG_OC_CHG_BIT = 3;
    localparam int HPP_HUB_STATUS_REG_OC_NOW_BIT = 1;

    // port power control byte layout
    localparam int HPP_PWR_EXT_LSB = 2;
    localparam int HPP_PWR_EXT_MSB = 5;
    localparam int HPP_PWR_INT_BIT = 1;

    // values after reset
    localparam logic [7:0] HPP_ADDR_RST = 8'h00;
    localparam logic [3:0] HPP_EXT_PWR_RST = 4'h0;
    localparam logic HPP_INT_PWR_RST = 1'b1;
    localparam logic HPP_SENSE_N_RST = 1'b1;

    // synchroniser depth in cycles
    localparam int HPP_SYNC_STAGES = 2;

    // per external port power state
    typedef enum logic [0:0] {
        HPP_PORT_OFF,
        HPP_PORT_DISCONNECTED
    } hpp_port_state_t;

endpackage

// [rtl/hpp_oc_if.sv]
// interface carrying the synchronised overcurrent sense level
// assumes both ends share clk_sys_in
`timescale 1ns/100ps
interface hpp_oc_if;
    logic sense_n_sync;
    modport src (output sense_n_sync);
    modport dst (input sense_n_sync);
endinterface

// [rtl/hpp_oc_sync.sv]
// two-flop synchroniser for the overcurrent sense pin
// assumes the pin is asynchronous to clk_sys_in; output is the second flop
`timescale 1ns/100ps
module hpp_oc_sync
    import hpp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic sense_n_in,
    hpp_oc_if.src oc
);
    logic [HPP_SYNC_STAGES-1:0] stage_r;
    logic [HPP_SYNC_STAGES-1:0] stage_nxt;

    always_comb begin
        stage_nxt = {stage_r[HPP_SYNC_STAGES-2:0], sense_n_in};
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            stage_r <= {HPP_SYNC_STAGES{HPP_SENSE_N_RST}};
        end else begin
            stage_r <= stage_nxt;
        end
    end

    assign oc.sense_n_sync = stage_r[HPP_SYNC_STAGES-1];
endmodule

// [rtl/hpp_port_power.sv]
// ganged downstream port power control with overcurrent handling
// assumes firmware strobes are one-cycle pulses synchronous to clk_sys_in;
// the overcurrent pin may be asynchronous and must be glitch free
`timescale 1ns/100ps
module hpp_port_power
    import hpp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic overcurrent_sense_n_in,
    input wire logic overcurrent_detect_en_in,
    input wire logic status_endpoint_en_in,
    input wire logic [3:0] ext_port_power_set_in,
    input wire logic [3:0] ext_port_power_clr_in,
    input wire logic overcurrent_change_clr_in,
    input wire logic hub_addr_wr_in,
    input wire logic function_addr_wr_in,
    input wire logic [7:0] addr_wdata_in,
    output logic port_power_enable_n_out,
    output logic [7:0] hub_status_reg_out,
    output logic [7:0] port_power_ctl_reg_out,
    output logic [3:0] ext_port_disconnected_out,
    output logic [7:0] hub_addr_reg_out,
    output logic [7:0] function_addr_reg_out
);

    function automatic logic any_set(input logic [3:0] bits);
        any_set = |bits;
    endfunction

    hpp_oc_if oc_link ();

    hpp_oc_sync hpp_oc_sync_inst (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .sense_n_in(overcurrent_sense_n_in),
        .oc(oc_link)
    );

    // status and power bit state
    logic [3:0] ext_port_power_bits_r;
    logic [3:0] ext_port_power_bits_nxt;
    logic internal_port_power_bit_r;
    logic internal_port_power_bit_nxt;
    logic overcurrent_now_r;
    logic overcurrent_now_nxt;
    logic overcurrent_change_flag_r;
    logic overcurrent_change_flag_nxt;
    logic overcurrent_detect_en_r;
    logic overcurrent_detect_en_nxt;
    logic power_req_r;
    logic power_req_nxt;
    logic oc_detect;
    logic oc_change;
    logic oc_cut_async;

    // address state
    logic [7:0] hub_addr_r;
    logic [7:0] hub_addr_nxt;
    logic [7:0] function_addr_r;
    logic [7:0] function_addr_nxt;

    // per-port state
    hpp_port_state_t port_state_r [HPP_EXT_PORTS];
    hpp_port_state_t port_state_nxt [HPP_EXT_PORTS];

    always_comb begin
        // overcurrent_now_r holds the previous synchronised level
        oc_detect = overcurrent_detect_en_in & overcurrent_now_r
            & ~oc_link.sense_n_sync;
        oc_change = overcurrent_detect_en_in
            & (overcurrent_now_r != oc_link.sense_n_sync);
        overcurrent_now_nxt = oc_link.sense_n_sync;
        overcurrent_detect_en_nxt = overcurrent_detect_en_in;
        // a firmware set in the detection cycle wins over the hardware clear
        ext_port_power_bits_nxt = (ext_port_power_bits_r & ~ext_port_power_clr_in
            & ~{4{oc_detect}}) | ext_port_power_set_in;
        overcurrent_change_flag_nxt = (overcurrent_change_flag_r
            & ~overcurrent_change_clr_in) | oc_change;
        internal_port_power_bit_nxt = HPP_INT_PWR_RST;
        // gate on the endpoint enable so an early write cannot power ports
        power_req_nxt = any_set(ext_port_power_bits_nxt)
            & status_endpoint_en_in;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ext_port_power_bits_r <= HPP_EXT_PWR_RST;
            internal_port_power_bit_r <= HPP_INT_PWR_RST;
            overcurrent_now_r <= HPP_SENSE_N_RST;
            overcurrent_change_flag_r <= 1'b0;
            overcurrent_detect_en_r <= 1'b0;
            power_req_r <= 1'b0;
        end else begin
            ext_port_power_bits_r <= ext_port_power_bits_nxt;
            internal_port_power_bit_r <= internal_port_power_bit_nxt;
            overcurrent_now_r <= overcurrent_now_nxt;
            overcurrent_change_flag_r <= overcurrent_change_flag_nxt;
            overcurrent_detect_en_r <= overcurrent_detect_en_nxt;
            power_req_r <= power_req_nxt;
        end
    end

    // the cut bypasses the clock so a short can be stopped in nanoseconds;
    // the cost is that any glitch on the pin drops power too
    always_comb begin
        oc_cut_async = overcurrent_detect_en_in & ~overcurrent_sense_n_in;
        port_power_enable_n_out = ~(power_req_r & ~oc_cut_async);
    end

    always_comb begin
        hub_addr_nxt = hub_addr_wr_in ? addr_wdata_in : hub_addr_r;
        function_addr_nxt = function_addr_wr_in ? addr_wdata_in : function_addr_r;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            hub_addr_r <= HPP_ADDR_RST;
            function_addr_r <= HPP_ADDR_RST;
        end else begin
            hub_addr_r <= hub_addr_nxt;
            function_addr_r <= function_addr_nxt;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < HPP_EXT_PORTS; gi++) begin : g_port
            always_comb begin
                case (port_state_r[gi])
                    HPP_PORT_OFF: begin
                        if (ext_port_power_bits_nxt[gi]) begin
                            port_state_nxt[gi] = HPP_PORT_DISCONNECTED;
                        end else begin
                            port_state_nxt[gi] = HPP_PORT_OFF;
                        end
                    end
                    HPP_PORT_DISCONNECTED: begin
                        // overcurrent clears the power bit, so the port drops to off
                        if (!ext_port_power_bits_nxt[gi]) begin
                            port_state_nxt[gi] = HPP_PORT_OFF;
                        end else begin
                            port_state_nxt[gi] = HPP_PORT_DISCONNECTED;
                        end
                    end
                    default: begin
                        port_state_nxt[gi] = HPP_PORT_OFF;
                    end
                endcase
            end

            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    port_state_r[gi] <= HPP_PORT_OFF;
                end else begin
                    port_state_r[gi] <= port_state_nxt[gi];
                end
            end

            assign ext_port_disconnected_out[gi] =
                (port_state_r[gi] == HPP_PORT_DISCONNECTED);
        end
    endgenerate

    always_comb begin
        hub_status_reg_out = 8'h00;
        hub_status_reg_out[HPP_HUB_STATUS_REG_OC_EN_BIT] = overcurrent_detect_en_r;
        hub_status_reg_out[HPP_HUB_STATUS_REG_OC_CHG_BIT] = overcurrent_change_flag_r;
        hub_status_reg_out[HPP_HUB_STATUS_REG_OC_NOW_BIT] = overcurrent_now_r;
        port_power_ctl_reg_out = 8'h00;
        port_power_ctl_reg_out[HPP_PWR_EXT_MSB:HPP_PWR_EXT_LSB] = ext_port_power_bits_r;
        port_power_ctl_reg_out[HPP_PWR_INT_BIT] = internal_port_power_bit_r;
        hub_addr_reg_out = hub_addr_r;
        function_addr_reg_out = function_addr_r;
    end

endmodule

// [test/hpp_pp_chk.sv]
// checker for the port power block
// assumes it is bound to hpp_port_power and sees only its ports
`timescale 1ns/100ps
module hpp_pp_chk (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic overcurrent_sense_n_in,
    input wire logic overcurrent_detect_en_in,
    input wire logic status_endpoint_en_in,
    input wire logic [3:0] ext_port_power_set_in,
    input wire logic [3:0] ext_port_power_clr_in,
    input wire logic overcurrent_change_clr_in,
    input wire logic port_power_enable_n_out,
    input wire logic [7:0] hub_status_reg_out,
    input wire logic [7:0] port_power_ctl_reg_out
);
    wire [3:0] pb = port_power_ctl_reg_out[5:2];
    wire en = hub_status_reg_out[7];
    wire now = hub_status_reg_out[1];
    // $past reaches three edges back, so checks wait until that history exists
    logic [1:0] warm_r;
    logic [1:0] warm_nxt;
    always_comb begin
        warm_nxt = (warm_r == 2'h3) ? warm_r : warm_r + 2'h1;
    end
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            warm_r <= 2'h0;
        end else begin
            warm_r <= warm_nxt;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in || warm_r != 2'h3);
    // the cut follows the live enable input, not the registered status copy
    chk_cut_power: assert property (
        !overcurrent_sense_n_in && overcurrent_detect_en_in |-> port_power_enable_n_out)
        else $error("power not cut");
    chk_now_sync: assert property (
        now == $past(overcurrent_sense_n_in, 3))
        else $error("indicator lag wrong");
    chk_flag_set: assert property (
        $changed(now) && en && $past(en) |-> hub_status_reg_out[3])
        else $error("change flag not set");
    chk_flag_hold: assert property (
        hub_status_reg_out[3] && !overcurrent_change_clr_in |=> hub_status_reg_out[3])
        else $error("change flag lost");
    chk_bits_clear: assert property (
        $fell(now) && en && $past(en) && $past(ext_port_power_set_in) == 4'h0
        |-> pb == 4'h0)
        else $error("bits kept on overcurrent");
    chk_keep_bits: assert property (
        !en && $past(ext_port_power_clr_in) == 4'h0 |-> (pb & $past(pb)) == $past(pb))
        else $error("bits dropped while disabled");
    // the power request is registered from the bits as they now read
    chk_power_on: assert property (
        |pb && $past(status_endpoint_en_in) && overcurrent_sense_n_in
        |-> !port_power_enable_n_out)
        else $error("power not enabled");
    chk_power_off: assert property (
        pb == 4'h0 || !$past(status_endpoint_en_in) |-> port_power_enable_n_out)
        else $error("power on without request");
    chk_fixed_bits: assert property (
        port_power_ctl_reg_out[1] && port_power_ctl_reg_out[7:6] == 2'h0
        && !port_power_ctl_reg_out[0])
        else $error("fixed control bits wrong");
    cover property ($fell(port_power_enable_n_out));
    cover property ($rose(hub_status_reg_out[3]));
    cover property ($fell(now) && !en);
endmodule

// [test/hpp_sw_model.sv]
// model of the board power switch and overcurrent sensor
// assumes the testbench commands faults; the sense line has a board pull-up
`timescale 1ns/100ps
module hpp_sw_model (
    input wire logic enable_n_in,
    input wire logic fault_in,
    output logic sense_n_out,
    output logic powered_out
);
    // one ganged switch feeds every external port, so one flag is enough
    assign powered_out = !enable_n_in;
    // sensor holds its level while the fault lasts, no latching of its own
    assign sense_n_out = !fault_in;
endmodule

// [test/hub_port_power_overcurrent_tb_top.sv]
// testbench for the port power block with its switch model
// assumes a 100 MHz clock and strobes driven at the rising edge
`timescale 1ns/100ps
module hub_port_power_overcurrent_tb_top;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic fault = 1'b0, oc_en = 1'b0, ep_en = 1'b0, fl_clr = 1'b0;
    logic [3:0] set = 4'h0, clr = 4'h0, disc;
    logic ha_wr = 1'b0, fa_wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic sense_n, pwr_n, powered;
    logic [7:0] status, ctl, haddr, function_addr_reg;
    int error_cnt = 0, total_checks = 0, cycles = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    hpp_port_power hpp_port_power_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .overcurrent_sense_n_in(sense_n), .overcurrent_detect_en_in(oc_en),
        .status_endpoint_en_in(ep_en), .ext_port_power_set_in(set), .ext_port_power_clr_in(clr),
        .overcurrent_change_clr_in(fl_clr), .hub_addr_wr_in(ha_wr), .function_addr_wr_in(fa_wr),
        .addr_wdata_in(wdata), .port_power_enable_n_out(pwr_n), .hub_status_reg_out(status),
        .port_power_ctl_reg_out(ctl), .ext_port_disconnected_out(disc),
        .hub_addr_reg_out(haddr), .function_addr_reg_out(function_addr_reg));
    hpp_sw_model hpp_sw_model_inst (.enable_n_in(pwr_n), .fault_in(fault),
        .sense_n_out(sense_n), .powered_out(powered));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask
    task automatic strobe(input logic [3:0] s, input logic [3:0] c, input logic f);
        @(posedge clk_sys_in);
        set <= s;
        clr <= c;
        fl_clr <= f;
        @(posedge clk_sys_in);
        set <= 4'h0;
        clr <= 4'h0;
        fl_clr <= 1'b0;
    endtask
    task automatic addr_wr(input logic hub, input logic [7:0] d);
        @(posedge clk_sys_in);
        ha_wr <= hub;
        fa_wr <= !hub;
        wdata <= d;
        @(posedge clk_sys_in);
        ha_wr <= 1'b0;
        fa_wr <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 1000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        tick(3);
        chk(status, 8'h02, "status reset");
        chk(ctl, 8'h02, "ctl reset");
        chk(haddr | function_addr_reg, 8'h00, "addr reset");
        addr_wr(1'b1, 8'h3c);
        addr_wr(1'b0, 8'h47);
        tick(1);
        chk(haddr, 8'h3c, "hub addr");
        chk(function_addr_reg, 8'h47, "function addr");
        $display("test reset done");
        strobe(4'h1, 4'h0, 1'b0);
        tick(2);
        chk(ctl, 8'h06, "set port2");
        chk({4'h0, disc}, 8'h01, "disconnected");
        chk({7'h0, pwr_n}, 8'h01, "no endpoint enable");
        @(posedge clk_sys_in);
        ep_en <= 1'b1;
        oc_en <= 1'b1;
        tick(2);
        chk({7'h0, pwr_n}, 8'h00, "power on");
        chk({7'h0, powered}, 8'h01, "switch on");
        strobe(4'h0, 4'h1, 1'b0);
        tick(2);
        chk({7'h0, pwr_n}, 8'h01, "internal bit only");
        $display("test power done");
        strobe(4'h8, 4'h0, 1'b0);
        tick(2);
        @(posedge clk_sys_in);
        fault <= 1'b1;
        #1;
        chk({7'h0, pwr_n}, 8'h01, "async cut");
        chk({7'h0, powered}, 8'h00, "switch off");
        tick(4);
        chk(status, 8'h88, "overcurrent status");
        chk(ctl, 8'h02, "bits cleared");
        chk({4'h0, disc}, 8'h00, "ports off");
        @(posedge clk_sys_in);
        fault <= 1'b0;
        tick(4);
        chk(status, 8'h8a, "overcurrent gone");
        chk({7'h0, pwr_n}, 8'h01, "stays off");
        strobe(4'h0, 4'h0, 1'b1);
        tick(1);
        chk(status, 8'h82, "flag cleared");
        strobe(4'h2, 4'h0, 1'b0);
        tick(2);
        chk({7'h0, pwr_n}, 8'h00, "re-enable");
        $display("test overcurrent done");
        // enable drops a cycle ahead so the cut path never sees a stale enable
        @(posedge clk_sys_in);
        oc_en <= 1'b0;
        @(posedge clk_sys_in);
        fault <= 1'b1;
        tick(4);
        chk(status, 8'h00, "disabled status");
        chk({7'h0, pwr_n}, 8'h00, "disabled no cut");
        chk(ctl, 8'h0a, "disabled bits kept");
        $display("test disabled done");
        give_verdict();
    end
endmodule
bind hpp_port_power hpp_pp_chk hpp_pp_chk_inst (.*);
